/* File: shared/cwd_defines.vh */
// constants for the configuration word decode and protection block
`ifndef CWD_DEFINES_VH
`define CWD_DEFINES_VH

// ==========================================================
// configuration space addresses
`define CWD_ADDR_W          16
`define CWD_WORD_W          14
`define CWD_ADDR_USER_ID0   16'h8000
`define CWD_ADDR_USER_ID3   16'h8003
`define CWD_ADDR_CFG_ONE    16'h8007
`define CWD_ADDR_CFG_TWO    16'h8008
`define CWD_ADDR_BOR_CTRL   16'h8010
`define CWD_ADDR_STATUS     16'h8011
`define CWD_PM_EXT_LAST     16'h7FFF

// ==========================================================
// erased word and reset values
`define CWD_WORD_ERASED     14'h3FFF
`define CWD_WORD_ZERO       14'h0000
`define CWD_USER_ID_RESET   14'h3FFF

// ==========================================================
// field positions of the first word
`define CWD_OSC_LSB         0
`define CWD_OSC_MSB         2
`define CWD_PWRT_BIT        5
`define CWD_PROG_PROT_BIT   7
`define CWD_EE_PROT_BIT     8
`define CWD_BOR_LSB         9
`define CWD_BOR_MSB         10

// field positions of the second word
`define CWD_WRT_LSB         0
`define CWD_WRT_MSB         1
`define CWD_STACK_RST_BIT   9

// bits of the status and brown-out control registers
`define CWD_BORCTL_SW_BIT   0
`define CWD_ST_BOR_BIT      0
`define CWD_ST_PWRT_BIT     1
`define CWD_ST_STACK_BIT    2
`define CWD_ST_LOADED_BIT   3
`define CWD_ST_CLKIO_BIT    4

// ==========================================================
// oscillator select codes
`define CWD_OSC_EXT_HIGH    3'h7
`define CWD_OSC_EXT_MID     3'h6
`define CWD_OSC_EXT_LOW     3'h5
`define CWD_OSC_INTERNAL    3'h4
`define CWD_OSC_RC          3'h3
`define CWD_OSC_XTAL_HIGH   3'h2
`define CWD_OSC_XTAL_MID    3'h1
`define CWD_OSC_XTAL_LOW    3'h0

// brown-out mode codes
`define CWD_BOR_ON          2'h3
`define CWD_BOR_RUN_ONLY    2'h2
`define CWD_BOR_SOFTWARE    2'h1
`define CWD_BOR_OFF         2'h0

// self-write guard codes and protected block ends
`define CWD_WRT_OFF         2'h3
`define CWD_WRT_SMALL       2'h2
`define CWD_WRT_MID         2'h1
`define CWD_WRT_ALL         2'h0
`define CWD_WRT_END_1FF     16'h01FF
`define CWD_WRT_END_3FF     16'h03FF
`define CWD_WRT_END_7FF     16'h07FF
`define CWD_WRT_END_FFF     16'h0FFF
`define CWD_PM_LARGE        1'b0

// ==========================================================
// timing: settle cycles after reset before the words are taken
`define CWD_LOAD_CYC        2'h3

`endif

/* File: hdl/cwd_sync2.v */
// two-stage synchroniser for a bus of pin levels
`timescale 1ns/1ps
module cwd_sync2 #(
  parameter WIDTH = 14
) (
  clock,
  arst_n,
  din,
  dout
);
  input  wire             clock;
  input  wire             arst_n;
  input  wire [WIDTH-1:0] din;
  output reg  [WIDTH-1:0] dout;

  reg [WIDTH-1:0] meta_r;

  // erased state is all ones, so the chain resets high as well
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= {WIDTH{1'b1}};
      dout   <= {WIDTH{1'b1}};
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule // cwd_sync2

/* File: hdl/cwd_config.v */
// configuration word decode, code protection gate and user id words
`timescale 1ns/1ps
`include "cwd_defines.vh"

module cwd_config (
  clock,
  arst_n,
  cfg_one_pin,
  cfg_two_pin,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  sleep_mode,
  stack_overflow,
  stack_underflow,
  cpu_pm_wr,
  cpu_pm_addr,
  ext_rd,
  ext_wr,
  ext_space_ee,
  ext_addr,
  ext_wdata,
  ext_mem_rdata,
  ext_rdata,
  ext_pm_wr_go,
  ext_ee_wr_go,
  cpu_pm_wr_go,
  pm_bulk_erase,
  ee_bulk_erase,
  osc_select,
  clock_input_pin_io,
  brownout_active,
  powerup_timer_on,
  stack_fault_reset,
  cfg_loaded
);
  input  wire                     clock;
  input  wire                     arst_n;
  input  wire [`CWD_WORD_W-1:0]   cfg_one_pin;
  input  wire [`CWD_WORD_W-1:0]   cfg_two_pin;
  input  wire [`CWD_ADDR_W-1:0]   reg_addr;
  input  wire [`CWD_WORD_W-1:0]   reg_wdata;
  input  wire                     reg_wr;
  input  wire                     reg_rd;
  output reg  [`CWD_WORD_W-1:0]   reg_rdata;
  input  wire                     sleep_mode;
  input  wire                     stack_overflow;
  input  wire                     stack_underflow;
  input  wire                     cpu_pm_wr;
  input  wire [`CWD_ADDR_W-1:0]   cpu_pm_addr;
  input  wire                     ext_rd;
  input  wire                     ext_wr;
  input  wire                     ext_space_ee;
  input  wire [`CWD_ADDR_W-1:0]   ext_addr;
  input  wire [`CWD_WORD_W-1:0]   ext_wdata;
  input  wire [`CWD_WORD_W-1:0]   ext_mem_rdata;
  output reg  [`CWD_WORD_W-1:0]   ext_rdata;
  output reg                      ext_pm_wr_go;
  output reg                      ext_ee_wr_go;
  output reg                      cpu_pm_wr_go;
  output reg                      pm_bulk_erase;
  output reg                      ee_bulk_erase;
  output reg  [2:0]               osc_select;
  output reg                      clock_input_pin_io;
  output reg                      brownout_active;
  output reg                      powerup_timer_on;
  output reg                      stack_fault_reset;
  output reg                      cfg_loaded;

  // ==========================================================
  // helper functions
  function is_user_id;
    input [`CWD_ADDR_W-1:0] a;
    begin
      is_user_id = (a >= `CWD_ADDR_USER_ID0) && (a <= `CWD_ADDR_USER_ID3);
    end
  endfunction

  // last address of the self-write protected block; all ones means none
  function [`CWD_ADDR_W-1:0] guard_end;
    input [1:0] code;
    begin
      case (code)
        `CWD_WRT_SMALL: guard_end = `CWD_WRT_END_1FF;
        `CWD_WRT_MID:   guard_end = `CWD_PM_LARGE ? `CWD_WRT_END_7FF : `CWD_WRT_END_3FF;
        `CWD_WRT_ALL:   guard_end = `CWD_PM_LARGE ? `CWD_WRT_END_FFF : `CWD_WRT_END_7FF;
        default:        guard_end = {`CWD_ADDR_W{1'b1}};
      endcase
    end
  endfunction

  // ==========================================================
  // configuration word capture
  wire [`CWD_WORD_W-1:0] one_sync;
  wire [`CWD_WORD_W-1:0] two_sync;

  cwd_sync2 #(.WIDTH(`CWD_WORD_W)) u_sync_one (
    .clock  (clock),
    .arst_n (arst_n),
    .din    (cfg_one_pin),
    .dout   (one_sync)
  );

  cwd_sync2 #(.WIDTH(`CWD_WORD_W)) u_sync_two (
    .clock  (clock),
    .arst_n (arst_n),
    .din    (cfg_two_pin),
    .dout   (two_sync)
  );

  reg [`CWD_WORD_W-1:0] cfg_one_r;
  reg [`CWD_WORD_W-1:0] cfg_two_r;
  reg [1:0]             load_cnt_r;
  reg                   loaded_r;

  // words are taken once after reset and then held; the settle count
  // lets the synchroniser flush out its reset value first
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfg_one_r  <= `CWD_WORD_ERASED;
      cfg_two_r  <= `CWD_WORD_ERASED;
      load_cnt_r <= 2'h0;
      loaded_r   <= 1'b0;
    end else if (!loaded_r) begin
      if (load_cnt_r == `CWD_LOAD_CYC) begin
        cfg_one_r <= one_sync;
        cfg_two_r <= two_sync;
        loaded_r  <= 1'b1;
      end else begin
        load_cnt_r <= load_cnt_r + 2'h1;
      end
    end
  end

  // ==========================================================
  // field decode
  wire [2:0] osc_f      = cfg_one_r[`CWD_OSC_MSB:`CWD_OSC_LSB];
  wire [1:0] bor_f      = cfg_one_r[`CWD_BOR_MSB:`CWD_BOR_LSB];
  wire       pwrt_n_f   = cfg_one_r[`CWD_PWRT_BIT];
  wire       pm_prot_n  = cfg_one_r[`CWD_PROG_PROT_BIT];
  wire       ee_prot_n  = cfg_one_r[`CWD_EE_PROT_BIT];
  wire [1:0] wrt_f      = cfg_two_r[`CWD_WRT_MSB:`CWD_WRT_LSB];
  wire       stack_en_f = cfg_two_r[`CWD_STACK_RST_BIT];

  reg  sw_bor_en_r;
  reg  bor_nxt;
  reg  clk_io_nxt;

  always @* begin
    case (bor_f)
      `CWD_BOR_ON:       bor_nxt = 1'b1;
      `CWD_BOR_RUN_ONLY: bor_nxt = !sleep_mode;
      `CWD_BOR_SOFTWARE: bor_nxt = sw_bor_en_r;
      default:           bor_nxt = 1'b0;
    endcase
  end

  // only the internal oscillator leaves the clock input pin free
  always @* begin
    case (osc_f)
      `CWD_OSC_EXT_HIGH:  clk_io_nxt = 1'b0;
      `CWD_OSC_EXT_MID:   clk_io_nxt = 1'b0;
      `CWD_OSC_EXT_LOW:   clk_io_nxt = 1'b0;
      `CWD_OSC_INTERNAL:  clk_io_nxt = 1'b1;
      `CWD_OSC_RC:        clk_io_nxt = 1'b0;
      `CWD_OSC_XTAL_HIGH: clk_io_nxt = 1'b0;
      `CWD_OSC_XTAL_MID:  clk_io_nxt = 1'b0;
      default:            clk_io_nxt = 1'b0;
    endcase
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      osc_select         <= `CWD_OSC_EXT_HIGH;
      clock_input_pin_io <= 1'b0;
      brownout_active    <= 1'b1;
      powerup_timer_on   <= 1'b0;
      stack_fault_reset  <= 1'b0;
      cfg_loaded         <= 1'b0;
    end else begin
      osc_select         <= osc_f;
      clock_input_pin_io <= clk_io_nxt;
      brownout_active    <= bor_nxt;
      // the timer follows its own bit only, never the brown-out mode
      powerup_timer_on   <= !pwrt_n_f;
      stack_fault_reset  <= stack_en_f && (stack_overflow || stack_underflow);
      cfg_loaded         <= loaded_r;
    end
  end

  // ==========================================================
  // cpu side self-write check; cpu reads never pass through here
  wire [`CWD_ADDR_W-1:0] wrt_end = guard_end(wrt_f);
  wire cpu_wr_ok = (wrt_f == `CWD_WRT_OFF) || (cpu_pm_addr > wrt_end);

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cpu_pm_wr_go <= 1'b0;
    end else begin
      cpu_pm_wr_go <= cpu_pm_wr && cpu_wr_ok;
    end
  end

  // ==========================================================
  // external programming port gate
  wire ext_cfg_space = ext_addr > `CWD_PM_EXT_LAST;
  wire ext_pm_hit    = !ext_space_ee && !ext_cfg_space;
  wire ext_ee_hit    = ext_space_ee;
  // the eeprom never enters this gate from the cpu side at all
  wire ext_pm_ok     = pm_prot_n;
  wire ext_ee_ok     = ee_prot_n;
  wire ext_one_wr    = ext_wr && !ext_space_ee && (ext_addr == `CWD_ADDR_CFG_ONE);

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ext_rdata     <= `CWD_WORD_ZERO;
      ext_pm_wr_go  <= 1'b0;
      ext_ee_wr_go  <= 1'b0;
      pm_bulk_erase <= 1'b0;
      ee_bulk_erase <= 1'b0;
    end else begin
      if (ext_rd) begin
        if (ext_pm_hit && !ext_pm_ok)
          ext_rdata <= `CWD_WORD_ZERO;
        else if (ext_ee_hit && !ext_ee_ok)
          ext_rdata <= `CWD_WORD_ZERO;
        else
          ext_rdata <= ext_mem_rdata;
      end
      ext_pm_wr_go  <= ext_wr && ext_pm_hit && ext_pm_ok;
      ext_ee_wr_go  <= ext_wr && ext_ee_hit && ext_ee_ok;
      // lifting a protection wipes what it guarded, so secrets never leak
      pm_bulk_erase <= ext_one_wr && !pm_prot_n &&
                       ext_wdata[`CWD_PROG_PROT_BIT];
      ee_bulk_erase <= ext_one_wr && !ee_prot_n &&
                       ext_wdata[`CWD_EE_PROT_BIT];
    end
  end

  // ==========================================================
  // software registers and user id words
  reg [`CWD_WORD_W-1:0] user_id_r [0:3];
  reg [`CWD_WORD_W-1:0] rd_nxt;
  wire [1:0]            uid_sel = reg_addr[1:0];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_uid
      always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          user_id_r[gi] <= `CWD_USER_ID_RESET;
        end else if (reg_wr && is_user_id(reg_addr) && (uid_sel == gi)) begin
          user_id_r[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sw_bor_en_r <= 1'b0;
    end else if (reg_wr && (reg_addr == `CWD_ADDR_BOR_CTRL)) begin
      sw_bor_en_r <= reg_wdata[`CWD_BORCTL_SW_BIT];
    end
  end

  always @* begin
    rd_nxt = `CWD_WORD_ZERO;
    if (is_user_id(reg_addr)) begin
      rd_nxt = user_id_r[uid_sel];
    end else begin
      case (reg_addr)
        `CWD_ADDR_CFG_ONE:  rd_nxt = cfg_one_r;
        `CWD_ADDR_CFG_TWO:  rd_nxt = cfg_two_r;
        `CWD_ADDR_BOR_CTRL: rd_nxt[`CWD_BORCTL_SW_BIT] = sw_bor_en_r;
        `CWD_ADDR_STATUS: begin
          rd_nxt[`CWD_ST_BOR_BIT]    = brownout_active;
          rd_nxt[`CWD_ST_PWRT_BIT]   = powerup_timer_on;
          rd_nxt[`CWD_ST_STACK_BIT]  = stack_en_f;
          rd_nxt[`CWD_ST_LOADED_BIT] = loaded_r;
          rd_nxt[`CWD_ST_CLKIO_BIT]  = clock_input_pin_io;
        end
        default:            rd_nxt = `CWD_WORD_ZERO;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= `CWD_WORD_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end else begin
      reg_rdata <= `CWD_WORD_ZERO;
    end
  end
endmodule // cwd_config

/* File: tb/cwd_config_properties.sv */
// timing checks on the ports of the configuration decode block
`timescale 1ns/1ps
module cwd_config_properties (
  input wire        clock,
  input wire        arst_n,
  input wire [13:0] cfg_one_pin,
  input wire [13:0] cfg_two_pin,
  input wire [15:0] reg_addr,
  input wire        reg_rd,
  input wire [13:0] reg_rdata,
  input wire        stack_overflow,
  input wire        stack_underflow,
  input wire        cpu_pm_wr,
  input wire [15:0] cpu_pm_addr,
  input wire        ext_rd,
  input wire        ext_wr,
  input wire        ext_space_ee,
  input wire [15:0] ext_addr,
  input wire [13:0] ext_wdata,
  input wire [13:0] ext_mem_rdata,
  input wire [13:0] ext_rdata,
  input wire        ext_pm_wr_go,
  input wire        ext_ee_wr_go,
  input wire        cpu_pm_wr_go,
  input wire        pm_bulk_erase,
  input wire [2:0]  osc_select,
  input wire        clock_input_pin_io,
  input wire        brownout_active,
  input wire        powerup_timer_on,
  input wire        stack_fault_reset,
  input wire        cfg_loaded
);
  // ==========================================================
  // helpers
  wire [15:0] guard_end;
  assign guard_end = (cfg_two_pin[1:0] == 2'h2) ? 16'h01FF :
                     (cfg_two_pin[1:0] == 2'h1) ? 16'h03FF : 16'h07FF;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // properties
  property p_osc_decode;
    cfg_loaded |-> osc_select == cfg_one_pin[2:0]
      && clock_input_pin_io == (cfg_one_pin[2:0] == 3'h4);
  endproperty
  a_osc_decode: assert property (p_osc_decode)
    else $error("oscillator decode differs from word one");
  property p_pwrt;
    cfg_loaded |-> powerup_timer_on == !cfg_one_pin[5];
  endproperty
  a_pwrt: assert property (p_pwrt)
    else $error("power-up timer not set by its own bit");
  property p_bor_fixed;
    cfg_loaded && cfg_one_pin[10] == cfg_one_pin[9] |-> brownout_active == cfg_one_pin[10];
  endproperty
  a_bor_fixed: assert property (p_bor_fixed)
    else $error("brown-out on/off code not honoured");
  property p_stack;
    cfg_loaded && (stack_overflow || stack_underflow) |=> stack_fault_reset == cfg_two_pin[9];
  endproperty
  a_stack: assert property (p_stack)
    else $error("stack fault reset wrong");
  property p_pm_read;
    cfg_loaded && ext_rd && !ext_space_ee && !ext_addr[15]
      |=> ext_rdata == (cfg_one_pin[7] ? $past(ext_mem_rdata) : 14'h0000);
  endproperty
  a_pm_read: assert property (p_pm_read)
    else $error("program read not gated");
  property p_ee_write;
    cfg_loaded && ext_wr && ext_space_ee |=> ext_ee_wr_go == cfg_one_pin[8];
  endproperty
  a_ee_write: assert property (p_ee_write)
    else $error("eeprom write not gated");
  property p_pm_write;
    cfg_loaded && ext_wr && !ext_space_ee && !ext_addr[15] |=> ext_pm_wr_go == cfg_one_pin[7];
  endproperty
  a_pm_write: assert property (p_pm_write)
    else $error("program write not gated");
  property p_self_write;
    cfg_loaded && cpu_pm_wr
      |=> cpu_pm_wr_go == (cfg_two_pin[1:0] == 2'h3 || $past(cpu_pm_addr) > guard_end);
  endproperty
  a_self_write: assert property (p_self_write)
    else $error("self-write guard wrong");
  property p_pm_erase;
    cfg_loaded && ext_wr && !ext_space_ee && ext_addr == 16'h8007 && ext_wdata[7]
      |=> pm_bulk_erase == !cfg_one_pin[7];
  endproperty
  a_pm_erase: assert property (p_pm_erase)
    else $error("program bulk erase wrong");
  property p_word_read;
    cfg_loaded && reg_rd && reg_addr == 16'h8007 |=> reg_rdata == cfg_one_pin;
  endproperty
  a_word_read: assert property (p_word_read)
    else $error("word one not at its address");
endmodule // cwd_config_properties

bind cwd_config cwd_config_properties u_props (
  .clock(clock), .arst_n(arst_n), .cfg_one_pin(cfg_one_pin), .cfg_two_pin(cfg_two_pin),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .stack_overflow(stack_overflow), .stack_underflow(stack_underflow),
  .cpu_pm_wr(cpu_pm_wr), .cpu_pm_addr(cpu_pm_addr), .ext_rd(ext_rd), .ext_wr(ext_wr),
  .ext_space_ee(ext_space_ee), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
  .ext_mem_rdata(ext_mem_rdata), .ext_rdata(ext_rdata), .ext_pm_wr_go(ext_pm_wr_go),
  .ext_ee_wr_go(ext_ee_wr_go), .cpu_pm_wr_go(cpu_pm_wr_go), .pm_bulk_erase(pm_bulk_erase),
  .osc_select(osc_select), .clock_input_pin_io(clock_input_pin_io),
  .brownout_active(brownout_active), .powerup_timer_on(powerup_timer_on),
  .stack_fault_reset(stack_fault_reset), .cfg_loaded(cfg_loaded));

/* File: tb/cwd_array_model.sv */
// memory array stand-in answering external reads
`timescale 1ns/1ps
module cwd_array_model (
  input  wire        clock,
  input  wire        ext_rd,
  input  wire        ext_space_ee,
  input  wire [15:0] ext_addr,
  output reg  [13:0] ext_mem_rdata
);
  // ==========================================================
  // outside a read the inverse of the last word is shown, so a late
  // sample by the gate reads garbage rather than a lucky match
  reg [13:0] last_r = 14'h0000;
  always @* begin
    if (ext_rd) begin
      ext_mem_rdata = {ext_space_ee, ext_addr[12:0]} ^ 14'h2A5A;
    end else begin
      ext_mem_rdata = ~last_r;
    end
  end
  always @(posedge clock) begin
    if (ext_rd) begin
      last_r <= ext_mem_rdata;
    end
  end
endmodule // cwd_array_model

/* File: tb/cwd_config_bench.sv */
// self-checking bench of the configuration decode block
`timescale 1ns/1ps
module cwd_config_bench;
  reg         clock = 1'b0;
  reg         arst_n = 1'b1;
  reg         sleep_mode = 1'b0;
  reg  [13:0] cfg_one_pin = 14'h3FFF;
  reg  [13:0] cfg_two_pin = 14'h3FFF;
  reg  [15:0] reg_addr = 16'h0000;
  reg  [13:0] reg_wdata = 14'h0000;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg         stack_overflow = 1'b0;
  reg         stack_underflow = 1'b0;
  reg         cpu_pm_wr = 1'b0;
  reg  [15:0] cpu_pm_addr = 16'h0000;
  reg         ext_rd = 1'b0;
  reg         ext_wr = 1'b0;
  reg         ext_space_ee = 1'b0;
  reg  [15:0] ext_addr = 16'h0000;
  reg  [13:0] ext_wdata = 14'h0000;
  wire [13:0] ext_mem_rdata, reg_rdata, ext_rdata;
  wire [2:0]  osc_select;
  wire        ext_pm_wr_go, ext_ee_wr_go, cpu_pm_wr_go, pm_bulk_erase, ee_bulk_erase;
  wire        clock_input_pin_io, brownout_active, powerup_timer_on, stack_fault_reset;
  wire        cfg_loaded;
  integer     err_count = 0;
  integer     n_compared = 0;
  integer     cyc = 0;
  integer     i;
  reg  [13:0] w;
  reg  [15:0] e;

  always #20 clock = ~clock;

  cwd_config dut (
    .clock(clock), .arst_n(arst_n), .cfg_one_pin(cfg_one_pin), .cfg_two_pin(cfg_two_pin),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sleep_mode(sleep_mode), .stack_overflow(stack_overflow),
    .stack_underflow(stack_underflow), .cpu_pm_wr(cpu_pm_wr), .cpu_pm_addr(cpu_pm_addr),
    .ext_rd(ext_rd), .ext_wr(ext_wr), .ext_space_ee(ext_space_ee), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_mem_rdata(ext_mem_rdata), .ext_rdata(ext_rdata),
    .ext_pm_wr_go(ext_pm_wr_go), .ext_ee_wr_go(ext_ee_wr_go), .cpu_pm_wr_go(cpu_pm_wr_go),
    .pm_bulk_erase(pm_bulk_erase), .ee_bulk_erase(ee_bulk_erase), .osc_select(osc_select),
    .clock_input_pin_io(clock_input_pin_io), .brownout_active(brownout_active),
    .powerup_timer_on(powerup_timer_on), .stack_fault_reset(stack_fault_reset),
    .cfg_loaded(cfg_loaded));
  cwd_array_model u_array (.clock(clock), .ext_rd(ext_rd), .ext_space_ee(ext_space_ee),
    .ext_addr(ext_addr), .ext_mem_rdata(ext_mem_rdata));

  // ==========================================================
  // shared tasks
  task chk(input [13:0] got, input [13:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk1(input got, input exp);
    chk({13'h0000, got}, {13'h0000, exp});
  endtask
  task do_reset(input [13:0] w1, input [13:0] w2);
    @(posedge clock);
    arst_n <= 1'b0;
    cfg_one_pin <= w1;
    cfg_two_pin <= w2;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    repeat (8) @(posedge clock);
    #1;
    chk1(cfg_loaded, 1'b1);
  endtask
  task reg_w(input [15:0] a, input [13:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task reg_r(input [15:0] a, input [13:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task ext_t(input wr, input ee, input [15:0] a, input [13:0] d);
    @(posedge clock);
    ext_wr <= wr;
    ext_rd <= !wr;
    ext_space_ee <= ee;
    ext_addr <= a;
    ext_wdata <= d;
    @(posedge clock);
    ext_wr <= 1'b0;
    ext_rd <= 1'b0;
    #1;
  endtask
  task cpu_t(input [15:0] a);
    @(posedge clock);
    cpu_pm_wr <= 1'b1;
    cpu_pm_addr <= a;
    @(posedge clock);
    cpu_pm_wr <= 1'b0;
    #1;
  endtask
  task stk_t(input ov);
    @(posedge clock);
    stack_overflow <= ov;
    stack_underflow <= !ov;
    @(posedge clock);
    stack_overflow <= 1'b0;
    stack_underflow <= 1'b0;
    #1;
  endtask

  // ==========================================================
  // scenarios
  task test_decode;
    for (i = 0; i < 8; i = i + 1) begin
      w = {3'h7, i[1:0], 3'h7, i[0], 2'h3, i[2:0]};
      do_reset(w, 14'h3FFF);
      chk({11'h000, osc_select}, w[13:0] & 14'h0007);
      chk1(clock_input_pin_io, i == 4);
      chk1(powerup_timer_on, !i[0]);
      chk1(brownout_active, i[1]);
      reg_r(16'h8007, w);
      reg_r(16'h8008, 14'h3FFF);
    end
    do_reset(14'h3BFF, 14'h3FFF);
    reg_w(16'h8010, 14'h0001);
    @(posedge clock);
    #1;
    chk1(brownout_active, 1'b1);
    // run-only brown-out mode drops out while asleep
    do_reset(14'h3DFF, 14'h3FFF);
    chk1(brownout_active, 1'b1);
    @(posedge clock);
    sleep_mode <= 1'b1;
    @(posedge clock);
    #1;
    chk1(brownout_active, 1'b0);
    @(posedge clock);
    sleep_mode <= 1'b0;
    @(posedge clock);
    #1;
    chk1(brownout_active, 1'b1);
    $display("test decode done");
  endtask
  task test_protect;
    for (i = 0; i < 4; i = i + 1) begin
      w = {5'h1F, i[1:0], 7'h7F};
      do_reset(w, 14'h3FFF);
      ext_t(1'b0, 1'b0, 16'h0010, 14'h0000);
      chk(ext_rdata, i[0] ? (14'h0010 ^ 14'h2A5A) : 14'h0000);
      ext_t(1'b0, 1'b1, 16'h0020, 14'h0000);
      chk(ext_rdata, i[1] ? (14'h2020 ^ 14'h2A5A) : 14'h0000);
      ext_t(1'b1, 1'b0, 16'h7FFF, 14'h0005);
      chk1(ext_pm_wr_go, i[0]);
      ext_t(1'b1, 1'b1, 16'h0003, 14'h0005);
      chk1(ext_ee_wr_go, i[1]);
      cpu_t(16'h0100);
      chk1(cpu_pm_wr_go, 1'b1);
      ext_t(1'b1, 1'b0, 16'h8007, 14'h3FFF);
      chk1(pm_bulk_erase, !i[0]);
      chk1(ee_bulk_erase, !i[1]);
      reg_r(16'h8007, w);
    end
    $display("test protect done");
  endtask
  task test_guard;
    for (i = 0; i < 4; i = i + 1) begin
      do_reset(14'h3FFF, {12'hFFF, i[1:0]});
      e = (i == 2) ? 16'h01FF : (i == 1) ? 16'h03FF : 16'h07FF;
      cpu_t(e);
      chk1(cpu_pm_wr_go, i == 3);
      cpu_t(e + 16'h0001);
      chk1(cpu_pm_wr_go, 1'b1);
    end
    $display("test guard done");
  endtask
  task test_stack_uid;
    for (i = 0; i < 2; i = i + 1) begin
      do_reset(14'h3FFF, {4'hF, i[0], 9'h1FF});
      stk_t(1'b1);
      chk1(stack_fault_reset, i[0]);
      stk_t(1'b0);
      chk1(stack_fault_reset, i[0]);
    end
    for (i = 0; i < 4; i = i + 1) begin
      reg_r(16'h8000 + i, 14'h3FFF);
      reg_w(16'h8000 + i, 14'h1230 + i);
    end
    for (i = 0; i < 4; i = i + 1) begin
      reg_r(16'h8000 + i, 14'h1230 + i);
    end
    reg_w(16'h8007, 14'h0000);
    reg_r(16'h8007, 14'h3FFF);
    reg_r(16'h9000, 14'h0000);
    $display("test stack and user id done");
  endtask

  task print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count = err_count + 1;
      print_verdict;
    end
  end

  initial begin
    // a real falling edge at time zero so every flop of the dut takes its reset value
    arst_n <= 1'b0;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    test_decode;
    test_protect;
    test_guard;
    test_stack_uid;
    print_verdict;
  end
endmodule // cwd_config_bench
